// ==== verilog/timer_output_postscaler.sv ====
// Purpose: 8/16-bit timer with input prescaler, output postscaler and APB registers
// Assumes: pclk 50 MHz; clock_in synchronous to pclk; sleep_in high while asleep
// Notes:   zero-wait APB slave; unmapped addresses answer with pslverr
// Functional notes
// - postscaler divides timer events by 1 to 16 via 4-bit select
// - postscaler count has no read or write path from software
// - postscaler cleared by low-byte write, control writes, or reset
// - 8-bit mode: output toggles when low count equals period byte
// - 16-bit mode: output toggles when high:low count rolls over
// - output is taken after the postscaler
// - timer output goes out to the pin output selector
// - control A carries a read-only copy of the output level
// - sync mode counts on the instruction clock and stops in sleep
// - async mode counts each rising source edge, also during sleep
// - input prescaler offers 1:1 to 1:32768 via 4-bit select
// - source code 000 is the pin, 001 the inverted pin
`include "timer_defines.svh"
module timer_output_postscaler (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire timer_pkg::apb_addr_t paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 clock_in,
  input  wire logic                 sleep_in,
  output logic                      timer_output
);
  import timer_pkg::*;

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  function automatic logic reg_hit(input apb_addr_t addr, input logic [11:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  reg_byte_t   count_low_q;
  reg_byte_t   count_high_q;
  reg_byte_t   ctrl_a_q;
  reg_byte_t   ctrl_b_q;
  logic        tmr_out_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  logic        access;
  logic        wr;
  logic        wr_low;
  logic        wr_high;
  logic        wr_ca;
  logic        wr_cb;
  logic        mapped;
  logic        clear_scalers;

  assign access  = psel & penable;
  assign wr      = access & pwrite;
  assign wr_low  = wr & reg_hit(paddr, `IDX_COUNT_LOW);
  assign wr_high = wr & reg_hit(paddr, `IDX_COUNT_HIGH);
  assign wr_ca   = wr & reg_hit(paddr, `IDX_CONTROL_A);
  assign wr_cb   = wr & reg_hit(paddr, `IDX_CONTROL_B);
  assign mapped  = reg_hit(paddr, `IDX_COUNT_LOW) | reg_hit(paddr, `IDX_COUNT_HIGH)
                 | reg_hit(paddr, `IDX_CONTROL_A) | reg_hit(paddr, `IDX_CONTROL_B);
  assign clear_scalers = wr_low | wr_ca | wr_cb;

  // --------------------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------------------
  logic              enable;
  logic              wide_mode;
  logic              async_mode;
  logic [3:0]        post_sel;
  logic [3:0]        pre_sel;
  clk_src_t          src_sel;

  assign enable     = ctrl_a_q[`CA_ENABLE_BIT];
  assign wide_mode  = ctrl_a_q[`CA_WIDE_BIT];
  assign post_sel   = ctrl_a_q[`CA_POST_HI:`CA_POST_LO];
  assign async_mode = ctrl_b_q[`CB_ASYNC_BIT];
  assign pre_sel    = ctrl_b_q[`CB_PRE_HI:`CB_PRE_LO];
  assign src_sel    = clk_src_t'(ctrl_b_q[`CB_SRC_HI:`CB_SRC_LO]);

  // --------------------------------------------------------------------------
  // instruction clock: pclk divided by four as an enable
  // --------------------------------------------------------------------------
  logic [1:0] div_q;
  logic       instr_tick;

  assign instr_tick = (div_q == `INSTR_DIV_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (!sleep_in) begin
      div_q <= div_q + 2'h1;
    end
  end

  // --------------------------------------------------------------------------
  // clock source and edge detection
  // --------------------------------------------------------------------------
  logic src_level;
  logic src_prev_q;
  logic src_rise;
  logic pend_q;
  logic count_edge;

  always_comb begin
    unique case (src_sel)
      src_pin:     src_level = clock_in;
      src_pin_inv: src_level = ~clock_in;
      src_instr:   src_level = instr_tick;
      default:     src_level = 1'b0;       // unused codes give no clock
    endcase
  end

  assign src_rise = src_level & ~src_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
    end
  end

  // sync mode: an edge waits for the next instruction tick
  // an edge that lands on the tick is counted there and must not stay pending,
  // or it would be counted a second time at the following tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else if (sleep_in) begin
      pend_q <= 1'b0; // no instruction clock asleep, so sync edges are lost
    end else if (instr_tick) begin
      pend_q <= pend_q & src_rise; // a fresh edge beside a drained one is kept
    end else if (src_rise) begin
      pend_q <= 1'b1;
    end
  end

  assign count_edge = enable & (async_mode ? src_rise
                                : (instr_tick & ~sleep_in & (pend_q | src_rise)));

  // --------------------------------------------------------------------------
  // input prescaler
  // --------------------------------------------------------------------------
  logic [`PRE_W-1:0] pre_cnt_q;
  logic [`PRE_W-1:0] pre_mask;
  logic              inc_tick;

  assign pre_mask = `PRE_W'((16'h1 << pre_sel) - 16'h1);
  assign inc_tick = count_edge & ((pre_cnt_q & pre_mask) == pre_mask) & ~clear_scalers;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= '0;
    end else if (clear_scalers) begin
      pre_cnt_q <= '0;
    end else if (count_edge) begin
      pre_cnt_q <= pre_cnt_q + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // counter and events
  // --------------------------------------------------------------------------
  logic match8;
  logic roll16;
  logic tmr_event;

  assign match8    = ~wide_mode & (count_low_q == count_high_q);
  assign roll16    = wide_mode & ({count_high_q, count_low_q} == `WIDE_MAX);
  assign tmr_event = inc_tick & (match8 | roll16);

  // software writes override the counter in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low_q <= `BYTE_RESET;
    end else if (wr_low) begin
      count_low_q <= pwdata[7:0];
    end else if (inc_tick) begin
      count_low_q <= match8 ? `BYTE_RESET : count_low_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_high_q <= `BYTE_RESET;
    end else if (wr_high) begin
      count_high_q <= pwdata[7:0];
    end else if (inc_tick && wide_mode && (count_low_q == 8'hff)) begin
      count_high_q <= count_high_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q <= `BYTE_RESET;
      ctrl_b_q <= `BYTE_RESET;
    end else begin
      if (wr_ca) begin
        ctrl_a_q <= pwdata[7:0];
      end
      if (wr_cb) begin
        ctrl_b_q <= pwdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // postscaler and output
  // --------------------------------------------------------------------------
  postscale_if ps_bus ();

  assign ps_bus.event_pulse = tmr_event;
  assign ps_bus.clear       = clear_scalers;
  assign ps_bus.ratio_sel   = post_sel;

  timer_postscaler u_post (
    .pclk    (pclk),
    .presetn (presetn),
    .ps      (ps_bus.scaler)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_out_q <= 1'b0;
    end else if (ps_bus.out_pulse) begin
      tmr_out_q <= ~tmr_out_q;
    end
  end

  assign timer_output = tmr_out_q;

  // --------------------------------------------------------------------------
  // apb read path
  // --------------------------------------------------------------------------
  reg_byte_t read_byte;

  always_comb begin
    read_byte = `BYTE_RESET;
    if (reg_hit(paddr, `IDX_COUNT_LOW)) begin
      read_byte = count_low_q;
    end else if (reg_hit(paddr, `IDX_COUNT_HIGH)) begin
      read_byte = count_high_q;
    end else if (reg_hit(paddr, `IDX_CONTROL_A)) begin
      read_byte = ctrl_a_q;
      read_byte[`CA_OUTPUT_BIT] = tmr_out_q;
    end else if (reg_hit(paddr, `IDX_CONTROL_B)) begin
      read_byte = ctrl_b_q;
    end
  end

  // captured in the setup cycle so the access cycle can finish at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q  <= {24'h000000, read_byte};
      pslverr_q <= ~mapped;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access & pslverr_q;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_low_write_clears: assert property (
    wr_low |=> (pre_cnt_q == '0) && (count_low_q == $past(pwdata[7:0])))
    else $error("low byte write did not clear prescaler");
  a_ctrl_write_clears: assert property (
    (wr_ca || wr_cb) |=> pre_cnt_q == '0)
    else $error("control write did not clear prescaler");
  a_match_wraps_zero: assert property (
    (inc_tick && match8 && !wr_low) |=> count_low_q == `BYTE_RESET)
    else $error("low byte did not restart after match");
  a_rollover_event: assert property (
    (inc_tick && wide_mode && {count_high_q, count_low_q} == `WIDE_MAX && !wr_low && !wr_high)
      |-> tmr_event ##1 ({count_high_q, count_low_q} == 16'h0000))
    else $error("wide rollover missed");
  a_toggle_cause: assert property (
    $changed(tmr_out_q) |-> $past(tmr_event) && !$past(clear_scalers))
    else $error("output toggled without an event");
  a_ratio_one_toggle: assert property (
    (tmr_event && post_sel == 4'h0 && !clear_scalers) |=> tmr_out_q != $past(tmr_out_q))
    else $error("ratio 1:1 did not toggle");
  a_status_readback: assert property (
    (psel && !penable && reg_hit(paddr, `IDX_CONTROL_A))
      |=> prdata[`CA_OUTPUT_BIT] == $past(tmr_out_q))
    else $error("status bit does not track output");
  a_sleep_stops_sync: assert property (
    (sleep_in && !async_mode) |-> !inc_tick)
    else $error("sync timer counted during sleep");
  a_async_counts_edge: assert property (
    (async_mode && enable && src_rise && pre_sel == 4'h0 && !clear_scalers) |-> inc_tick)
    else $error("async edge not counted");
  a_disabled_holds: assert property (
    (!enable && !wr_low && !wr_high) [*2] |-> $stable(count_low_q) && $stable(tmr_out_q))
    else $error("count moved while disabled");
  a_unmapped_error: assert property (
    (psel && !penable && !mapped) ##1 (psel && penable) |-> pslverr && pready)
    else $error("unmapped access not flagged");

  c_narrow_toggle: cover property (!wide_mode && ps_bus.out_pulse);
  c_wide_rollover: cover property (wide_mode && tmr_event);
  c_post_ratio_max: cover property (post_sel == 4'hf && ps_bus.out_pulse);
  c_async_sleep: cover property (async_mode && sleep_in && inc_tick);
endmodule

// ==== verilog/timer_defines.svh ====
// Purpose: named constants for the timer output stage
// Assumes: included by every design file that needs a number
// Notes:   register indices are word indices; byte address is four times the index
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define ADDR_W          16
`define IDX_COUNT_LOW   12'h59c
`define IDX_COUNT_HIGH  12'h59d
`define IDX_CONTROL_A   12'h59e
`define IDX_CONTROL_B   12'h59f
`define BYTE_RESET      8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CA_ENABLE_BIT   7
`define CA_OUTPUT_BIT   5
`define CA_WIDE_BIT     4
`define CA_POST_HI      3
`define CA_POST_LO      0
`define CB_SRC_HI       7
`define CB_SRC_LO       5
`define CB_ASYNC_BIT    4
`define CB_PRE_HI       3
`define CB_PRE_LO       0

// ----------------------------------------------------------------------------
// counts
// ----------------------------------------------------------------------------
`define INSTR_DIV_LAST  2'h3
`define PRE_W           15
`define POST_W          4
`define WIDE_MAX        16'hffff

`endif

// ==== verilog/timer_pkg.sv ====
// Purpose: shared types of the timer output stage
// Assumes: nothing
// Notes:   numbers live in timer_defines.svh
package timer_pkg;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [15:0] apb_addr_t;
  typedef enum logic [2:0] {
    src_pin,
    src_pin_inv,
    src_instr
  } clk_src_t;
endpackage

// ==== verilog/postscale_if.sv ====
// Purpose: carrier between the timer core and its output postscaler
// Assumes: single clock
// Notes:   out_pulse is combinational from the scaler
interface postscale_if;
  logic       event_pulse;
  logic       clear;
  logic [3:0] ratio_sel;
  logic       out_pulse;
  modport timer  (output event_pulse, output clear, output ratio_sel, input out_pulse);
  modport scaler (input event_pulse, input clear, input ratio_sel, output out_pulse);
endinterface

// ==== verilog/timer_postscaler.sv ====
// Purpose: output postscaler, one pulse every (select+1) events
// Assumes: events are one-cycle pulses on pclk
// Notes:   count has no software path; clear beats a same-cycle event
`include "timer_defines.svh"
module timer_postscaler (
  input  wire logic         pclk,
  input  wire logic         presetn,
  postscale_if.scaler       ps
);
  import timer_pkg::*;

  logic [`POST_W-1:0] cnt_q;
  logic               last;

  assign last         = (cnt_q == ps.ratio_sel);
  // pulse suppressed on clear so a rewrite never leaks a stale toggle
  assign ps.out_pulse = ps.event_pulse & last & ~ps.clear;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (ps.clear) begin
      cnt_q <= '0;
    end else if (ps.event_pulse) begin
      cnt_q <= last ? '0 : cnt_q + 1'b1;
    end
  end

  a_post_in_range: assert property (@(posedge pclk) disable iff (!presetn)
    (ps.event_pulse && !ps.clear && $stable(ps.ratio_sel) && cnt_q <= ps.ratio_sel)
      |=> cnt_q <= ps.ratio_sel)
    else $error("postscaler count passed its ratio");
  a_post_clears: assert property (@(posedge pclk) disable iff (!presetn)
    ps.clear |=> cnt_q == '0)
    else $error("postscaler count not cleared");
endmodule

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the timer output stage, driven over APB and clock_in
// Assumes: zero-wait APB slave, byte address is four times the register index
// Notes:   expected output level is tracked by the bench from the event count
`include "timer_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  localparam apb_addr_t a_low  = {2'b00, `IDX_COUNT_LOW, 2'b00};
  localparam apb_addr_t a_high = {2'b00, `IDX_COUNT_HIGH, 2'b00};
  localparam apb_addr_t a_ca   = {2'b00, `IDX_CONTROL_A, 2'b00};
  localparam apb_addr_t a_cb   = {2'b00, `IDX_CONTROL_B, 2'b00};
  localparam apb_addr_t a_none = 16'h1680;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  apb_addr_t   paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clock_in;
  logic        sleep_in;
  logic        timer_output;
  int          n_mismatch;
  int          checked;
  logic        exp_out;
  logic [31:0] rdat;
  logic        rerr;

  timer_output_postscaler dut_u (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .clock_in     (clock_in),
    .sleep_in     (sleep_in),
    .timer_output (timer_output)
  );

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input apb_addr_t a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input apb_addr_t a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input apb_addr_t a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(what, rdat, {24'h000000, exp});
  endtask

  // high phases of four cycles and low phases of five between pulses suit both sync and async counting
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk) clock_in <= 1'b1;
      repeat (4) @(posedge pclk);
      clock_in <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    rd_chk("count_low", a_low, 8'h00);
    rd_chk("count_high", a_high, 8'h00);
    rd_chk("control_a", a_ca, 8'h00);
    rd_chk("control_b", a_cb, 8'h00);
    chk("timer_output", timer_output, 1'b0);
    chk("pready", pready, 1'b1);
    wr(a_none, 8'h5a);
    chk("pslverr", rerr, 1'b1);
    rd_chk("unmapped", a_none, 8'h00);
    chk("pslverr", rerr, 1'b1);
    rd_chk("count_high", a_high, 8'h00);
  endtask

  // period 3 gives four ticks per event; the output bit written high is ignored
  task automatic t_match();
    int s_list[3] = '{0, 1, 15};
    foreach (s_list[i]) begin
      wr(a_high, 8'h03);
      wr(a_low, 8'h00);
      wr(a_cb, 8'h10);
      wr(a_ca, 8'ha0 | 8'(s_list[i]));
      pulse(3);
      rd_chk("count_low", a_low, 8'h03);
      pulse(4 * s_list[i]);
      chk("timer_output", timer_output, exp_out);
      pulse(1);
      exp_out = ~exp_out;
      chk("timer_output", timer_output, exp_out);
      rd_chk("control_a", a_ca, 8'h80 | {2'b00, exp_out, 5'h00} | 8'(s_list[i]));
      rd_chk("count_low", a_low, 8'h00);
    end
  endtask

  // every tick is an event with period 0; ratio 1:2
  task automatic t_clear();
    apb_addr_t  regs[3] = '{a_low, a_ca, a_cb};
    logic [7:0] vals[3] = '{8'h00, 8'h81, 8'h10};
    wr(a_high, 8'h00);
    wr(a_ca, 8'h81);
    wr(a_cb, 8'h10);
    wr(a_low, 8'h00);
    foreach (regs[k]) begin
      pulse(1);
      chk("timer_output", timer_output, exp_out);
      wr(regs[k], vals[k]);
      pulse(1);
      chk("timer_output", timer_output, exp_out);
      pulse(1);
      exp_out = ~exp_out;
      chk("timer_output", timer_output, exp_out);
    end
  endtask

  task automatic t_wide();
    wr(a_ca, 8'h90);
    wr(a_cb, 8'h10);
    wr(a_high, 8'hff);
    wr(a_low, 8'hfd);
    pulse(2);
    rd_chk("count_low", a_low, 8'hff);
    chk("timer_output", timer_output, exp_out);
    pulse(1);
    exp_out = ~exp_out;
    chk("timer_output", timer_output, exp_out);
    rd_chk("count_low", a_low, 8'h00);
    rd_chk("count_high", a_high, 8'h00);
  endtask

  task automatic t_enable();
    wr(a_ca, 8'h00);
    wr(a_low, 8'h05);
    pulse(3);
    rd_chk("count_low", a_low, 8'h05);
    chk("timer_output", timer_output, exp_out);
  endtask

  task automatic t_source();
    wr(a_ca, 8'h90);
    wr(a_high, 8'h00);
    @(posedge pclk) clock_in <= 1'b1;
    wr(a_cb, 8'h30);
    wr(a_low, 8'h00);
    @(posedge pclk) clock_in <= 1'b0;
    repeat (6) @(posedge pclk);
    rd_chk("count_low", a_low, 8'h01);
    @(posedge pclk) clock_in <= 1'b1;
    repeat (6) @(posedge pclk);
    rd_chk("count_low", a_low, 8'h01);
    @(posedge pclk) clock_in <= 1'b0;
    repeat (6) @(posedge pclk);
    rd_chk("count_low", a_low, 8'h02);
    wr(a_cb, 8'h12);
    wr(a_low, 8'h00);
    pulse(7);
    rd_chk("count_low", a_low, 8'h01);
    pulse(1);
    rd_chk("count_low", a_low, 8'h02);
    wr(a_cb, 8'h00);
    wr(a_low, 8'h00);
    pulse(2);
    rd_chk("count_low", a_low, 8'h02);
    @(posedge pclk) sleep_in <= 1'b1;
    pulse(2);
    rd_chk("count_low", a_low, 8'h02);
    wr(a_cb, 8'h10);
    wr(a_low, 8'h00);
    pulse(2);
    rd_chk("count_low", a_low, 8'h02);
    @(posedge pclk) sleep_in <= 1'b0;
  endtask

  // internal tick source, async then sync: read captures twelve cycles apart see three counts
  task automatic t_instr();
    logic [7:0] first;
    logic [7:0] cfg[2] = '{8'h50, 8'h40};
    foreach (cfg[k]) begin
      wr(a_cb, cfg[k]);
      xfer(1'b0, a_low, 8'h00);
      first = rdat[7:0];
      repeat (9) @(posedge pclk);
      xfer(1'b0, a_low, 8'h00);
      chk("tick_count", {24'h000000, rdat[7:0] - first}, 32'h00000003);
    end
  endtask

  // --------------------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 16'h0000;
    pwdata     = 32'h00000000;
    clock_in   = 1'b0;
    sleep_in   = 1'b0;
    n_mismatch = 0;
    checked    = 0;
    exp_out    = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_match();
    t_clear();
    t_wide();
    t_enable();
    t_source();
    t_instr();
    wrap_up();
  end

  // the whole sequence needs under 1500 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
